// file: logic/iev_ctrl.sv
/*
  Interrupt enable registers and vectoring controller.
  Holds the three enable registers, latches source request flags,
  picks the next interrupt and forces a call to its vector.
  Assumes the core strobes instr_cycle_i once per instruction cycle,
  reports the return-from-interrupt instruction on reti_i, and gives
  each source a two-bit priority level on prio_i (higher wins).
*/
// Behaviour
// R1: Global enable off means no interrupt is ever acknowledged.
// R2: Group A bits 5..0 gate sleep timer, AES, rx1, rx0, ADC, radio txrx.
// R3: Group B bits 5..0 gate port0, timer4, timer3, timer2, timer1, DMA.
// R4: Group C bits 5..0 gate watchdog, port1, tx1, tx0, port2, radio general.
// R5: Unused enable bits ignore writes and read zero.
// R6: An acknowledged interrupt redirects execution to its source vector.
// R7: During service only a strictly higher priority may preempt.
// R8: Return from interrupt ends the active service level.
// R9: Request flags set regardless of any enable.
// R10: Enabled flagged source is acknowledged next instruction cycle by call.
// R11: Equal or lower requests wait until they are highest outstanding.
// R12: Minimum latency is one detect plus six call cycles.
// R13: Vectors start at 03h and step by eight to 8Bh.
// R14: A flag clears when the core vectors to its routine.
// R15: Same priority ties go to the lowest source number.
`timescale 1ns/1ns
`default_nettype none
`include "iev_defines.svh"

module iev_ctrl
    import iev_pkg::*;
#(
    parameter int NUM_SRC = `IEV_NUM_SRC
)
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [7:0]           sfr_addr_i,
    input  wire logic                 sfr_wr_i,
    input  wire logic [7:0]           sfr_wdata_i,
    output logic      [7:0]           sfr_rdata_o,
    input  wire logic [NUM_SRC-1:0]   src_event_i,
    input  wire logic [2*NUM_SRC-1:0] prio_i,
    input  wire logic                 instr_cycle_i,
    input  wire logic                 reti_i,
    output logic                      call_req_o,
    output logic      [15:0]          vector_o,
    output logic      [NUM_SRC-1:0]   flag_o,
    output logic      [3:0]           active_levels_o
);

    // Enable map and vector table are fixed at eighteen sources
    if (NUM_SRC != `IEV_NUM_SRC)
    begin : g_bad_num_src
        $error("iev_ctrl serves exactly eighteen sources");
    end

    // ============================================================
    // Whole state of the module
    typedef struct packed {
        logic [7:0]         en_a;
        logic [7:0]         en_b;
        logic [7:0]         en_c;
        logic [NUM_SRC-1:0] flag;
        iev_state_t         state;
        logic [2:0]         cnt;
        iev_src_t           src;
        logic [1:0]         level;
        logic [3:0]         active;
        logic [15:0]        vector;
    } iev_ctrl_t;

    iev_ctrl_t st_r;
    iev_ctrl_t st_nxt;

    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] eligible;
    logic               win_found;
    iev_src_t           win_src;
    logic [1:0]         win_level;

    // True when level lv is above every level in service, for preemption
    function automatic logic preempts(input logic [3:0] act, input logic [1:0] lv);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++)
            if (act[i] && (2'(i) >= lv))
                ok = 1'b0;
        return ok;
    endfunction

    // Vector for a source number
    function automatic logic [15:0] vec_of(input iev_src_t s);
        return `IEV_VEC_BASE + 16'(s) * `IEV_VEC_STEP;
    endfunction

    // ============================================================
    // Per-source enable map in vector order
    always_comb
    begin
        src_en     = '0;
        src_en[0]  = st_r.en_a[0];  // R2
        src_en[1]  = st_r.en_a[1];  // R2
        src_en[2]  = st_r.en_a[2];  // R2
        src_en[3]  = st_r.en_a[3];  // R2
        src_en[4]  = st_r.en_a[4];  // R2
        src_en[5]  = st_r.en_a[5];  // R2
        src_en[6]  = st_r.en_c[1];  // R4
        src_en[7]  = st_r.en_c[2];  // R4
        src_en[8]  = st_r.en_b[0];  // R3
        src_en[9]  = st_r.en_b[1];  // R3
        src_en[10] = st_r.en_b[2];  // R3
        src_en[11] = st_r.en_b[3];  // R3
        src_en[12] = st_r.en_b[4];  // R3
        src_en[13] = st_r.en_b[5];  // R3
        src_en[14] = st_r.en_c[3];  // R4
        src_en[15] = st_r.en_c[4];  // R4
        src_en[16] = st_r.en_c[0];  // R4
        src_en[17] = st_r.en_c[5];  // R4
    end

    // Requests that may be acknowledged at all
    assign eligible = st_r.en_a[`IEV_GLOBAL_EN_BIT] ? (st_r.flag & src_en) : '0; // R1

    iev_arbiter #(
        .NUM_SRC (NUM_SRC)
    ) u_arb (
        .req_i   (eligible),
        .prio_i  (prio_i),
        .found_o (win_found),
        .src_o   (win_src),
        .level_o (win_level)
    );

    // ============================================================
    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // Register writes; unused bits forced to zero
        if (sfr_wr_i && sfr_addr_i == `IEV_ADDR_GROUP_A)
            st_nxt.en_a = sfr_wdata_i & `IEV_GROUP_A_MASK;   // R5
        if (sfr_wr_i && sfr_addr_i == `IEV_ADDR_GROUP_B)
            st_nxt.en_b = sfr_wdata_i & `IEV_GROUP_BC_MASK;  // R5
        if (sfr_wr_i && sfr_addr_i == `IEV_ADDR_GROUP_C)
            st_nxt.en_c = sfr_wdata_i & `IEV_GROUP_BC_MASK;  // R5

        // Return ends highest active level
        if (reti_i)                                           // R8
        begin
            for (int i = 0; i < 4; i++)
                if (st_r.active[i] && !(|(st_r.active >> (i + 1))))
                    st_nxt.active[i] = 1'b0;
        end

        unique case (st_r.state)
            IEV_IDLE, IEV_SERVE:
            begin
                // Detect cycle: take winner if it outranks service
                if (instr_cycle_i && win_found
                    && preempts(st_r.active, win_level))      // R7 R11 R15
                begin
                    st_nxt.state = IEV_CALL;                  // R10
                    st_nxt.src   = win_src;
                    st_nxt.level = win_level;
                    st_nxt.cnt   = 3'(`IEV_CALL_CYCLES - 1);  // R12
                    st_nxt.flag[win_src] = 1'b0;              // R14
                end
            end
            IEV_CALL:
            begin
                if (instr_cycle_i)
                begin
                    if (st_r.cnt == 3'h0)
                    begin
                        st_nxt.state  = IEV_SERVE;            // R6
                        st_nxt.vector = vec_of(st_r.src);     // R13
                        st_nxt.active[st_r.level] = 1'b1;
                    end
                    else
                        st_nxt.cnt = st_r.cnt - 3'h1;
                end
            end
            default:
                st_nxt.state = IEV_IDLE;
        endcase

        if (st_nxt.state == IEV_SERVE && st_nxt.active == 4'h0)
            st_nxt.state = IEV_IDLE;

        // New events set flags; set wins over hardware clear
        st_nxt.flag = st_nxt.flag | src_event_i;              // R9
    end

    // ============================================================
    // State register
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r        <= '0;
            st_r.en_a   <= `IEV_EN_RESET;
            st_r.en_b   <= `IEV_EN_RESET;
            st_r.en_c   <= `IEV_EN_RESET;
            st_r.state  <= IEV_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    // ============================================================
    // Read mux and outputs
    always_comb
    begin
        unique case (sfr_addr_i)
            `IEV_ADDR_GROUP_A: sfr_rdata_o = st_r.en_a;
            `IEV_ADDR_GROUP_B: sfr_rdata_o = st_r.en_b;
            `IEV_ADDR_GROUP_C: sfr_rdata_o = st_r.en_c;
            default:           sfr_rdata_o = 8'h00;
        endcase
    end

    // One-cycle call pulse when the forced call completes
    assign call_req_o      = (st_r.state == IEV_CALL) && instr_cycle_i
                             && (st_r.cnt == 3'h0);
    assign vector_o        = st_r.vector;
    assign flag_o          = st_r.flag;
    assign active_levels_o = st_r.active;

    // ============================================================
    // Checks
    chk_global_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
        (st_r.state != IEV_CALL && !st_r.en_a[`IEV_GLOBAL_EN_BIT])
        |=> st_r.state != IEV_CALL) else $error("call with global enable off");
    chk_unused_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R5
        st_r.en_a[6] == 1'b0 && st_r.en_b[7:6] == 2'b00 && st_r.en_c[7:6] == 2'b00)
        else $error("unused enable bit set");
    chk_vector_map: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
        call_req_o |=> vector_o == 16'h0003 + 16'(st_r.src) * 16'h0008)
        else $error("wrong vector");
    chk_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
        src_event_i[3] |=> flag_o[3]) else $error("event lost");
    chk_flag_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R14
        (st_r.state != IEV_CALL && st_nxt.state == IEV_CALL && !src_event_i[win_src])
        |=> !st_r.flag[st_r.src]) else $error("flag not cleared");
    chk_call_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
        $rose(st_r.state == IEV_CALL) |-> st_r.cnt == 3'h5)
        else $error("call length wrong");
    chk_preempt_rank: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R7
        (st_r.state == IEV_SERVE && st_nxt.state == IEV_CALL)
        |-> preempts(st_r.active, st_nxt.level)) else $error("bad preemption");
    chk_reti_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        (reti_i && st_r.state != IEV_CALL && st_r.active == 4'h1)
        |=> st_r.active == 4'h0) else $error("return kept level");

endmodule

`default_nettype wire

// file: logic/iev_defines.svh
/*
  Constants for the interrupt enable and vectoring block: register
  addresses, field positions, reset values, vector layout and timing.
  Assumes inclusion by bare name from design files.
*/
`ifndef IEV_DEFINES_SVH
`define IEV_DEFINES_SVH

// ============================================================
// Register addresses on the special-function register port
`define IEV_ADDR_GROUP_A     8'hA8
`define IEV_ADDR_GROUP_B     8'hB8
`define IEV_ADDR_GROUP_C     8'h9A

// ============================================================
// Field positions and masks
`define IEV_GLOBAL_EN_BIT    7
`define IEV_GROUP_A_MASK     8'hBF
`define IEV_GROUP_BC_MASK    8'h3F
`define IEV_EN_RESET         8'h00

// ============================================================
// Vector layout and timing
`define IEV_VEC_BASE         16'h0003
`define IEV_VEC_STEP         16'h0008
`define IEV_DETECT_CYCLES    1
`define IEV_CALL_CYCLES      6
`define IEV_NUM_SRC          18

`endif

// file: logic/iev_pkg.sv
/*
  Types for the interrupt enable and vectoring block.
  Assumes iev_defines.svh is available on the include path.
*/
`include "iev_defines.svh"

package iev_pkg;

    // Controller sequencing states
    typedef enum logic [1:0] {
        IEV_IDLE  = 2'b00,
        IEV_CALL  = 2'b01,
        IEV_SERVE = 2'b10
    } iev_state_t;

    typedef logic [4:0] iev_src_t;

endpackage

// file: logic/iev_arbiter.sv
/*
  Priority picker: chooses the lowest-numbered request at the highest
  priority level present. Pure combinational.
  Assumes request and priority vectors are stable within a cycle.
*/
`timescale 1ns/1ns
`default_nettype none

module iev_arbiter
    import iev_pkg::*;
#(
    parameter int NUM_SRC = 18
)
(
    input  wire logic [NUM_SRC-1:0]   req_i,
    input  wire logic [2*NUM_SRC-1:0] prio_i,
    output logic                      found_o,
    output iev_src_t                  src_o,
    output logic      [1:0]           level_o
);

    // ============================================================
    // Winner number must fit the five-bit source field
    if (NUM_SRC < 1 || NUM_SRC > 32)
    begin : g_bad_num_src
        $error("iev_arbiter serves one to thirty-two sources");
    end

    // ============================================================
    // Scan levels low to high, sources high to low so highest level and lowest source win
    always_comb
    begin
        found_o = 1'b0;
        src_o   = '0;
        level_o = 2'b00;
        for (int lv = 0; lv < 4; lv++)
        begin
            for (int s = NUM_SRC - 1; s >= 0; s--)
            begin
                if (req_i[s] && (prio_i[2*s +: 2] == 2'(lv)))
                begin
                    found_o = 1'b1;
                    src_o   = 5'(s);
                    level_o = 2'(lv);
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: testbench/iev_core_model.sv
/*
  Core-side model: strobes instruction cycles every gap clocks, returns
  from interrupts on request and counts forced calls and their latency.
  Assumes it shares sys_clk_i and rst_n_i with the controller.
*/
`timescale 1ns/1ns
`default_nettype none

module iev_core_model
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [17:0] src_event_i,
    input  wire logic        call_req_i,
    output logic             instr_cycle_o,
    output logic             reti_o
);
    int gap   = 1;
    int phase = 0;
    int n_ins = 0;
    int base  = 0;
    int lat   = 0;
    int calls = 0;

    // ============================================================
    // Instruction strobe, one pulse every gap clocks
    initial instr_cycle_o = 1'b0;
    initial reti_o = 1'b0;
    always @(negedge sys_clk_i)
    begin
        instr_cycle_o <= rst_n_i && (phase == 0);
        phase = (phase + 1) % gap;
    end

    // Count strobes from the flag-setting edge to the forced call
    always @(posedge sys_clk_i)
    begin
        if (instr_cycle_o)
            n_ins = n_ins + 1;
        if (|src_event_i)
            base = n_ins;
        if (call_req_i)
        begin
            lat = n_ins - base;
            calls = calls + 1;
        end
    end

    // Return from interrupt, one clock long
    task automatic ret();
        @(negedge sys_clk_i);
        reti_o <= 1'b1;
        @(negedge sys_clk_i);
        reti_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// file: testbench/iev_ctrl_bench.sv
/*
  Self-checking bench for the interrupt enable and vectoring controller.
  Assumes iev_core_model plays the core; source events come from here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "iev_defines.svh"

module iev_ctrl_bench;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic        wr    = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [17:0] ev    = 18'h00000;
    logic [35:0] prio  = 36'h000000000;
    logic        instr;
    logic        reti;
    logic        call;
    logic [7:0]  rdata;
    logic [15:0] vec;
    logic [17:0] flag;
    logic [3:0]  act;
    int          fail_count = 0;
    int          n_tests    = 0;

    // ============================================================
    // Clock, controller and core model
    always #10 clk = ~clk;

    iev_ctrl i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .src_event_i(ev), .prio_i(prio),
        .instr_cycle_i(instr), .reti_i(reti), .call_req_o(call), .vector_o(vec),
        .flag_o(flag), .active_levels_o(act));

    iev_core_model p (.sys_clk_i(clk), .rst_n_i(rst_n), .src_event_i(ev),
        .call_req_i(call), .instr_cycle_o(instr), .reti_o(reti));

    // ============================================================
    // Shared tasks
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic reset_dut();
        rst_n = 1'b0;
        ev = 18'h00000;
        prio = 36'h000000000;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        #2;
        chk("read data", {10'h000, exp}, {10'h000, rdata});
    endtask

    task automatic fire(input logic [17:0] m);
        @(negedge clk);
        ev = m;
        @(negedge clk);
        ev = 18'h00000;
    endtask

    // Wait for n new forced calls; with n zero, watch the whole span
    task automatic wait_call(input int n, input int span);
        int c0;
        int k;
        c0 = p.calls;
        k = 0;
        while (k < span && (n == 0 || p.calls - c0 < n))
        begin
            @(negedge clk);
            k++;
        end
        chk("call count", 18'(n), 18'(p.calls - c0));
    endtask

    // Enable address and bit of each source
    function automatic logic [11:0] en_of(input int s);
        if (s < 6)
            return {`IEV_ADDR_GROUP_A, 4'(s)};
        if (s >= 8 && s < 14)
            return {`IEV_ADDR_GROUP_B, 4'(s - 8)};
        case (s)
            6:  return {`IEV_ADDR_GROUP_C, 4'h1};
            7:  return {`IEV_ADDR_GROUP_C, 4'h2};
            14: return {`IEV_ADDR_GROUP_C, 4'h3};
            15: return {`IEV_ADDR_GROUP_C, 4'h4};
            16: return {`IEV_ADDR_GROUP_C, 4'h0};
            default: return {`IEV_ADDR_GROUP_C, 4'h5};
        endcase
    endfunction

    // ============================================================
    // Scenarios
    task automatic t_regs();
        reset_dut();
        rd_chk(`IEV_ADDR_GROUP_A, 8'h00);
        wr_reg(`IEV_ADDR_GROUP_A, 8'hFF);
        wr_reg(`IEV_ADDR_GROUP_B, 8'hFF);
        wr_reg(`IEV_ADDR_GROUP_C, 8'hFF);
        rd_chk(`IEV_ADDR_GROUP_A, 8'hBF);
        rd_chk(`IEV_ADDR_GROUP_B, 8'h3F);
        rd_chk(`IEV_ADDR_GROUP_C, 8'h3F);
        rd_chk(8'h55, 8'h00);
    endtask

    task automatic t_mask();
        reset_dut();
        wr_reg(`IEV_ADDR_GROUP_B, 8'h01);
        fire(18'h00100);
        wait_call(0, 40);
        chk("flag", 18'h00100, flag);
        wr_reg(`IEV_ADDR_GROUP_A, 8'h80);
        fire(18'h20000);
        wait_call(1, 40);
        chk("vector", 18'h00043, {2'b00, vec});
        wait_call(0, 40);
        chk("flag", 18'h20000, flag);
    endtask

    // Every source in turn, strobing slow and fast
    task automatic t_vectors();
        logic [11:0] e;
        for (int s = 0; s < 18; s++)
        begin
            reset_dut();
            p.gap = (s % 2) ? 3 : 1;
            e = en_of(s);
            wr_reg(`IEV_ADDR_GROUP_A, 8'h80);
            wr_reg(e[11:4], 8'h01 << e[3:0] | (e[11:4] == `IEV_ADDR_GROUP_A ? 8'h80 : 8'h00));
            fire(18'h00001 << s);
            wait_call(1, 60);
            chk("latency", 18'(`IEV_DETECT_CYCLES + `IEV_CALL_CYCLES), 18'(p.lat));
            chk("vector", 18'(16'h0003 + 16'(8 * s)), {2'b00, vec});
            chk("flag", 18'h00000, flag);
            chk("active", 18'h1, {14'h0000, act});
            p.ret();
            chk("active", 18'h0, {14'h0000, act});
        end
        p.gap = 1;
    endtask

    task automatic t_prio();
        reset_dut();
        prio[25:24] = 2'b11;
        wr_reg(`IEV_ADDR_GROUP_A, 8'h88);
        wr_reg(`IEV_ADDR_GROUP_B, 8'h12);
        fire(18'h00208);
        wait_call(1, 40);
        chk("vector", 18'h0001B, {2'b00, vec});
        wait_call(0, 40);
        chk("flag", 18'h00200, flag);
        fire(18'h01000);
        wait_call(1, 40);
        chk("vector", 18'h00063, {2'b00, vec});
        chk("active", 18'h9, {14'h0000, act});
        p.ret();
        chk("active", 18'h1, {14'h0000, act});
        wait_call(0, 40);
        p.ret();
        wait_call(1, 40);
        chk("vector", 18'h0004B, {2'b00, vec});
    endtask

    // ============================================================
    // Main sequence and watchdog of about 40000 clocks
    initial
    begin
        t_regs();
        t_mask();
        t_vectors();
        t_prio();
        complete_run();
    end

    initial
    begin
        #800000;
        fail_count++;
        complete_run();
    end
endmodule

`default_nettype wire
